// *** pin_port_regs.vh ***
// register offsets, field positions, reset values and widths of the
// multifunction pin port
// assumes inclusion by bare name from the design files of this port
`ifndef PIN_PORT_REGS_VH
`define PIN_PORT_REGS_VH

// register offsets on the plain register port
`define AUX_CFG_OFFSET 8'h16
`define PIN_LEVEL_OFFSET 8'h17

// widths
`define ADDR_WIDTH 8
`define DATA_WIDTH 16
`define PIN_COUNT 6

// aux_pin_config_reg fields
`define SERIAL_SEL_BIT 15
`define DIGITAL_SEL_MSB 13
`define DIGITAL_SEL_LSB 8
`define DIRECTION_MSB 5
`define DIRECTION_LSB 0

// pin_level_reg fields
`define OUT_LEVEL_MSB 13
`define OUT_LEVEL_LSB 8
`define IN_LEVEL_MSB 5
`define IN_LEVEL_LSB 0

// reset values
`define SERIAL_SEL_RESET 1'h0
`define DIGITAL_SEL_RESET 6'h3F
`define DIRECTION_RESET 6'h00
`define OUT_LEVEL_RESET 6'h00
`define IN_LEVEL_RESET 6'h00

// pins taken over by the two-wire controller
`define DATA_LINE_PIN 0
`define CLOCK_LINE_PIN 1

// synchroniser depth for pin inputs
`define SYNC_STAGES 3

`endif

// *** pin_input_sync.v ***
// three-stage synchroniser with agreement filter for asynchronous pins
// assumes the inputs come from pads outside the clk domain
`timescale 1ns/1ps

module pin_input_sync #(
  parameter WIDTH = 6
) (
  input wire clk,
  input wire reset_n,
  input wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] stage1_q;
  reg [WIDTH-1:0] stage2_q;
  reg [WIDTH-1:0] stage3_q;
  reg [WIDTH-1:0] stable_q;
  integer i;

  // stage1 feeds only stage2; the filter looks at stages 2 and 3
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1_q <= {WIDTH{1'b0}};
      stage2_q <= {WIDTH{1'b0}};
      stage3_q <= {WIDTH{1'b0}};
      stable_q <= {WIDTH{1'b0}};
    end else begin
      stage1_q <= asyncIn;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
      // a level counts only once two stages agree, hiding one-cycle glitches
      for (i = 0; i < WIDTH; i = i + 1) begin
        if (stage2_q[i] == stage3_q[i]) begin
          stable_q[i] <= stage3_q[i];
        end
      end
    end
  end

  assign syncOut = stable_q;

endmodule

// *** multifunction_pin_port.v ***
// six-pin multifunction port: analog/digital select, direction, output
// level, sampled input level, and two-wire controller takeover of pins 1:0
// assumes a same-clock transport that pulses addrParityDone at the end of
// the parity bit after the address byte of a read, and a two-wire engine
// that asks for the lines to be pulled low
`timescale 1ns/1ps
`include "pin_port_regs.vh"

module multifunction_pin_port #(
  parameter PINS = `PIN_COUNT
) (
  input wire clk,
  input wire reset_n,
  input wire [`ADDR_WIDTH-1:0] addr,
  input wire [`DATA_WIDTH-1:0] wdata,
  input wire writeStrobe,
  input wire readStrobe,
  output wire [`DATA_WIDTH-1:0] rdata,
  input wire addrParityDone,
  input wire [PINS-1:0] pinIn,
  output wire [PINS-1:0] pinOut,
  output wire [PINS-1:0] pinOe,
  output wire [PINS-1:0] pinPulldown,
  output wire [PINS-1:0] pinAnalogSel,
  output wire [PINS-1:0] inputBufferEn,
  input wire [PINS-1:0] measureEnableSecond,
  output wire [PINS-1:0] auxMeasureEn,
  input wire sdaDriveLow,
  input wire sclDriveLow,
  output wire sdaIn,
  output wire sclIn,
  output wire serialActive
);

  localparam DATA_PIN = `DATA_LINE_PIN;
  localparam CLK_PIN = `CLOCK_LINE_PIN;

  // clears the two pins owned by the serial controller when it is active
  function [PINS-1:0] dropSerialPins;
    input [PINS-1:0] value;
    input serialOn;
    begin
      dropSerialPins = value;
      if (serialOn) begin
        dropSerialPins[DATA_PIN] = 1'b0;
        dropSerialPins[CLK_PIN] = 1'b0;
      end
    end
  endfunction

  // places a six-bit field into a register word at the given low bit
  function [`DATA_WIDTH-1:0] placeField;
    input [PINS-1:0] value;
    input integer lsb;
    begin
      placeField = {`DATA_WIDTH{1'b0}};
      placeField = {{(`DATA_WIDTH-PINS){1'b0}}, value} << lsb;
    end
  endfunction

  // software-visible configuration state
  reg serialSel_q;
  reg [PINS-1:0] digitalSel_q;
  reg [PINS-1:0] direction_q;
  reg [PINS-1:0] outputLevel_q;

  // input level snapshot taken during a read transaction
  reg [PINS-1:0] levelSnapshot_q;

  // registered pin controls
  reg [PINS-1:0] pinOut_q;
  reg [PINS-1:0] pinOe_q;
  reg [PINS-1:0] pinPulldown_q;
  reg [PINS-1:0] pinAnalogSel_q;
  reg [PINS-1:0] inputBufferEn_q;
  reg [PINS-1:0] auxMeasureEn_q;
  reg sdaIn_q;
  reg sclIn_q;
  reg serialActive_q;

  reg [PINS-1:0] pinOut_d;
  reg [PINS-1:0] pinOe_d;
  reg [PINS-1:0] pinPulldown_d;
  reg [PINS-1:0] pinAnalogSel_d;
  reg [PINS-1:0] inputBufferEn_d;
  reg [PINS-1:0] auxMeasureEn_d;

  // register read path
  reg [`DATA_WIDTH-1:0] rdata_q;
  reg [`DATA_WIDTH-1:0] rdata_d;

  wire [PINS-1:0] pinLevelSync;
  wire writeAuxCfg;
  wire writeLevel;
  wire [PINS-1:0] digitalEff;
  wire [PINS-1:0] directionEff;
  wire [PINS-1:0] levelEff;
  wire [PINS-1:0] levelVisible;

  // pads are asynchronous to clk, so every pin level is synchronised
  pin_input_sync #(
    .WIDTH(PINS)
  ) inputSync (
    .clk(clk),
    .reset_n(reset_n),
    .asyncIn(pinIn),
    .syncOut(pinLevelSync)
  );

  // address decode of the two registers
  assign writeAuxCfg = writeStrobe && (addr == `AUX_CFG_OFFSET);
  assign writeLevel = writeStrobe && (addr == `PIN_LEVEL_OFFSET);

  // configuration writes; unused and read-only bits are simply not stored
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      serialSel_q <= `SERIAL_SEL_RESET;
      digitalSel_q <= `DIGITAL_SEL_RESET;
      direction_q <= `DIRECTION_RESET;
      outputLevel_q <= `OUT_LEVEL_RESET;
    end else begin
      if (writeAuxCfg) begin
        serialSel_q <= wdata[`SERIAL_SEL_BIT];
        digitalSel_q <= wdata[`DIGITAL_SEL_MSB:`DIGITAL_SEL_LSB];
        direction_q <= wdata[`DIRECTION_MSB:`DIRECTION_LSB];
      end
      if (writeLevel) begin
        // only the output field is stored; input bits 5:0 are dropped
        outputLevel_q <= wdata[`OUT_LEVEL_MSB:`OUT_LEVEL_LSB];
      end
    end
  end

  // settings as seen by the pins: serial mode masks pins 1:0, stored bits
  // stay untouched so that reads return what software wrote
  assign digitalEff = dropSerialPins(digitalSel_q, serialSel_q);
  assign directionEff = dropSerialPins(direction_q, serialSel_q);
  assign levelEff = dropSerialPins(outputLevel_q, serialSel_q);

  // pin control decode for every pin
  integer p;
  always @* begin
    pinOut_d = {PINS{1'b0}};
    pinOe_d = {PINS{1'b0}};
    pinPulldown_d = {PINS{1'b0}};
    pinAnalogSel_d = {PINS{1'b0}};
    inputBufferEn_d = {PINS{1'b0}};
    auxMeasureEn_d = {PINS{1'b0}};
    for (p = 0; p < PINS; p = p + 1) begin
      if (digitalEff[p]) begin
        // the buffer runs in both directions so the pad stays readable
        inputBufferEn_d[p] = 1'b1;
        if (directionEff[p]) begin
          pinOut_d[p] = levelEff[p];
          pinOe_d[p] = 1'b1;
        end else begin
          pinPulldown_d[p] = 1'b1;
        end
      end else begin
        // analog mode leaves the pad high-z for the measurement path
        pinAnalogSel_d[p] = 1'b1;
        auxMeasureEn_d[p] = measureEnableSecond[p];
      end
    end
    if (serialSel_q) begin
      // open-drain lines: output level is always low, enable pulls down
      pinAnalogSel_d[DATA_PIN] = 1'b0;
      pinAnalogSel_d[CLK_PIN] = 1'b0;
      auxMeasureEn_d[DATA_PIN] = 1'b0;
      auxMeasureEn_d[CLK_PIN] = 1'b0;
      pinOut_d[DATA_PIN] = 1'b0;
      pinOut_d[CLK_PIN] = 1'b0;
      pinOe_d[DATA_PIN] = sdaDriveLow;
      pinOe_d[CLK_PIN] = sclDriveLow;
      // the data line is two-way, the clock line is read for stretching
      inputBufferEn_d[DATA_PIN] = 1'b1;
      inputBufferEn_d[CLK_PIN] = 1'b1;
    end
  end

  // pin controls come from flip-flops; one cycle of latency after a write
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pinOut_q <= {PINS{1'b0}};
      pinOe_q <= {PINS{1'b0}};
      pinPulldown_q <= {PINS{1'b0}};
      pinAnalogSel_q <= {PINS{1'b0}};
      inputBufferEn_q <= {PINS{1'b0}};
      auxMeasureEn_q <= {PINS{1'b0}};
      serialActive_q <= 1'b0;
    end else begin
      pinOut_q <= pinOut_d;
      pinOe_q <= pinOe_d;
      pinPulldown_q <= pinPulldown_d;
      pinAnalogSel_q <= pinAnalogSel_d;
      inputBufferEn_q <= inputBufferEn_d;
      auxMeasureEn_q <= auxMeasureEn_d;
      serialActive_q <= serialSel_q;
    end
  end

  // line levels handed to the two-wire engine; zero when serial mode is off
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sdaIn_q <= 1'b0;
      sclIn_q <= 1'b0;
    end else begin
      sdaIn_q <= serialSel_q & pinLevelSync[DATA_PIN];
      sclIn_q <= serialSel_q & pinLevelSync[CLK_PIN];
    end
  end

  // snapshot of pad levels, frozen between read transactions so a slow
  // register transfer reports one consistent set of bits
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      levelSnapshot_q <= `IN_LEVEL_RESET;
    end else if (addrParityDone) begin
      levelSnapshot_q <= pinLevelSync;
    end
  end

  // non-digital pins and serial-owned pins read as zero
  assign levelVisible = levelSnapshot_q & digitalEff;

  // read data mux; unmapped addresses answer zero
  always @* begin
    rdata_d = {`DATA_WIDTH{1'b0}};
    if (readStrobe) begin
      case (addr)
        `AUX_CFG_OFFSET: begin
          // stored bits come back even while serial mode masks them
          rdata_d[`SERIAL_SEL_BIT] = serialSel_q;
          rdata_d = rdata_d | placeField(digitalSel_q,
                                         `DIGITAL_SEL_LSB);
          rdata_d = rdata_d | placeField(direction_q,
                                         `DIRECTION_LSB);
        end
        `PIN_LEVEL_OFFSET: begin
          rdata_d = placeField(outputLevel_q, `OUT_LEVEL_LSB);
          rdata_d = rdata_d | placeField(levelVisible,
                                         `IN_LEVEL_LSB);
        end
        default: begin
          rdata_d = {`DATA_WIDTH{1'b0}};
        end
      endcase
    end
  end

  // read data stand for exactly the cycle after the read strobe
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= {`DATA_WIDTH{1'b0}};
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;
  assign pinOut = pinOut_q;
  assign pinOe = pinOe_q;
  assign pinPulldown = pinPulldown_q;
  assign pinAnalogSel = pinAnalogSel_q;
  assign inputBufferEn = inputBufferEn_q;
  assign auxMeasureEn = auxMeasureEn_q;
  assign sdaIn = sdaIn_q;
  assign sclIn = sclIn_q;
  assign serialActive = serialActive_q;

endmodule

// *** pin_pad_model.sv ***
// pad model for the six multifunction pins and what hangs on them
// assumes the port drives pinOut only where pinOe is high
`timescale 1ns/1ps
module pin_pad_model (
  input wire logic [5:0] pinOut,
  input wire logic [5:0] pinOe,
  input wire logic serialActive,
  input wire logic [5:0] extLevel,
  output logic [5:0] pad
);
  // a driven pad follows the port; the two-wire lines float up to their
  // pull-ups, so a released line never keeps its last value
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (pinOe[i])
        pad[i] = pinOut[i];
      else if (serialActive && i < 2)
        pad[i] = 1'b1;
      else
        pad[i] = extLevel[i];
    end
  end
endmodule

// *** multifunction_pin_port_checker.sv ***
// concurrent checks on the multifunction pin port outputs
// assumes a bind onto multifunction_pin_port with six pins
`timescale 1ns/1ps
module multifunction_pin_port_checker (
  input wire clk,
  input wire reset_n,
  input wire readStrobe,
  input wire [7:0] addr,
  input wire [15:0] rdata,
  input wire [5:0] pinOut,
  input wire [5:0] pinOe,
  input wire [5:0] pinPulldown,
  input wire [5:0] pinAnalogSel,
  input wire [5:0] inputBufferEn,
  input wire [5:0] auxMeasureEn,
  input wire sdaDriveLow,
  input wire sclDriveLow,
  input wire sdaIn,
  input wire sclIn,
  input wire serialActive
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // read data only in the cycle after a read strobe
  rdata_idle_a: assert property (!readStrobe |=> rdata == 16'h0000)
    else $error("rdata not zero outside a read");
  // bit 15 carries the serial select on the config read, so it is not here
  read_only_a: assert property ((rdata & 16'h40C0) == 16'h0000)
    else $error("unused bits read nonzero");
  // a one-cycle guard skips the edge where serial mode toggles
  sda_follow_a: assert property (serialActive && $past(serialActive)
    |-> pinOe[0] == $past(sdaDriveLow))
    else $error("data line enable does not follow engine");
  scl_follow_a: assert property (serialActive && $past(serialActive)
    |-> pinOe[1] == $past(sclDriveLow))
    else $error("clock line enable does not follow engine");
  open_drain_a: assert property (serialActive ##1 serialActive
    |-> pinOut[1:0] == 2'h0)
    else $error("two-wire line driven high");
  serial_mask_a: assert property (serialActive ##1 serialActive
    |-> ((pinPulldown | pinAnalogSel | auxMeasureEn) & 6'h03) == 6'h00)
    else $error("pin settings leak into two-wire lines");
  pull_input_a: assert property (
    (pinPulldown & (pinOe | pinAnalogSel)) == 6'h00)
    else $error("pull-down on a non-input pin");
  analog_hiz_a: assert property (
    (pinAnalogSel & pinOe) == 6'h00)
    else $error("analog pin driven");
  buffer_on_a: assert property ((pinOe & ~inputBufferEn) == 6'h00)
    else $error("driven pin without input buffer");
  // only the level register hides pins 1:0; the config read shows them
  serial_read_a: assert property ($past(readStrobe) && $past(addr) == 8'h17
    && serialActive && $past(serialActive) |-> rdata[1:0] == 2'h0)
    else $error("two-wire pins show input level");
  lines_quiet_a: assert property (!serialActive ##1 !serialActive
    |-> !sdaIn && !sclIn)
    else $error("line inputs active outside serial mode");
  serial_cov: cover property (serialActive && sdaDriveLow);
  drive_cov: cover property (pinOe[5] && pinOut[5]);
  read_cov: cover property (readStrobe ##1 rdata != 16'h0000);
endmodule

bind multifunction_pin_port multifunction_pin_port_checker
  multifunction_pin_port_checker_inst (.clk, .reset_n, .readStrobe, .addr,
  .rdata, .pinOut, .pinOe, .pinPulldown, .pinAnalogSel, .inputBufferEn,
  .auxMeasureEn, .sdaDriveLow, .sclDriveLow, .sdaIn, .sclIn,
  .serialActive);

// *** tb_multifunction_pin_port.sv ***
// self-checking bench for the multifunction pin port
// assumes the port, its pad model and its checker compile alongside
`timescale 1ns/1ps
module tb_multifunction_pin_port;
  logic clk, reset_n, writeStrobe, readStrobe, addrParityDone;
  logic sdaDriveLow, sclDriveLow, sdaIn, sclIn, serialActive;
  logic [7:0] addr;
  logic [15:0] wdata, rdata;
  logic [5:0] pinIn, pinOut, pinOe, pinPulldown, pinAnalogSel;
  logic [5:0] inputBufferEn, measureEnableSecond, auxMeasureEn, extLevel;
  logic [5:0] dg, dr, lv, ex, pd;
  logic [31:0] seed;
  int fail_count = 0;
  int cmp_count = 0;

  multifunction_pin_port multifunction_pin_port_inst (.clk, .reset_n,
    .addr, .wdata, .writeStrobe, .readStrobe, .rdata, .addrParityDone,
    .pinIn, .pinOut, .pinOe, .pinPulldown, .pinAnalogSel, .inputBufferEn,
    .measureEnableSecond, .auxMeasureEn, .sdaDriveLow, .sclDriveLow,
    .sdaIn, .sclIn, .serialActive);
  pin_pad_model pin_pad_model_inst (.pinOut, .pinOe, .serialActive,
    .extLevel, .pad(pinIn));

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input string n, input logic [15:0] e, g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk6(input string n, input logic [5:0] e, g);
    chk(n, {10'h000, e}, {10'h000, g});
  endtask
  // one-cycle strobes, changed just after the edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    writeStrobe <= 1'b1;
    @(posedge clk);
    writeStrobe <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    readStrobe <= 1'b1;
    @(posedge clk);
    readStrobe <= 1'b0;
    @(negedge clk);
    chk("rdata", e, rdata);
  endtask
  // stands in for the end of the address parity bit of a read
  task automatic snap;
    @(posedge clk);
    addrParityDone <= 1'b1;
    @(posedge clk);
    addrParityDone <= 1'b0;
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // the whole run is well under a thousand cycles
  initial begin
    #20000;
    fail_count++;
    tally_and_finish;
  end

  initial begin
    reset_n = 1'b0;
    addr = 8'h00;
    wdata = 16'h0000;
    writeStrobe = 1'b0;
    readStrobe = 1'b0;
    addrParityDone = 1'b0;
    sdaDriveLow = 1'b0;
    sclDriveLow = 1'b0;
    measureEnableSecond = 6'h3F;
    extLevel = 6'h00;
    seed = 32'hF9536C94;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    rd(8'h16, 16'h3F00);
    rd(8'h17, 16'h0000);
    wr(8'h18, 16'hFFFF);
    rd(8'h18, 16'h0000);
    rd(8'h16, 16'h3F00);
    // random modes, directions, levels and outside drive
    for (int i = 0; i < 8; i++) begin
      repeat (24) seed = lfsr(seed);
      {ex, lv, dr, dg} = seed[23:0];
      extLevel <= ex;
      wr(8'h16, {2'h0, dg, 2'h0, dr});
      wr(8'h17, {2'h3, lv, 8'hFF});
      repeat (6) @(posedge clk);
      snap;
      pd = (dg & dr & lv) | (~(dg & dr) & ex);
      rd(8'h16, {2'h0, dg, 2'h0, dr});
      rd(8'h17, {2'h0, lv, 2'h0, pd & dg});
      chk6("oe", dg & dr, pinOe);
      chk6("out", lv & dg & dr, pinOut & pinOe);
      chk6("pull", dg & ~dr, pinPulldown);
      chk6("analog", ~dg, pinAnalogSel);
      chk6("measure", ~dg, auxMeasureEn);
      chk6("buffer", dg, inputBufferEn);
      extLevel <= ~ex;
      repeat (6) @(posedge clk);
      rd(8'h17, {2'h0, lv, 2'h0, pd & dg});
    end
    // two-wire takeover of pins 1:0, both set as driving-high outputs
    extLevel <= 6'h00;
    wr(8'h17, 16'h0300);
    wr(8'h16, 16'h8F03);
    sdaDriveLow <= 1'b1;
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk6("oe", 6'h01, pinOe);
    chk6("out", 6'h00, pinOut & 6'h03);
    chk6("pull", 6'h0C, pinPulldown);
    chk6("measure", 6'h30, auxMeasureEn);
    chk6("analog", 6'h30, pinAnalogSel);
    chk6("buffer", 6'h0F, inputBufferEn);
    chk6("lines", 6'h02, {4'h0, sclIn, sdaIn});
    snap;
    rd(8'h17, 16'h0300);
    rd(8'h16, 16'h8F03);
    @(posedge clk);
    sdaDriveLow <= 1'b0;
    sclDriveLow <= 1'b1;
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk6("oe", 6'h02, pinOe);
    chk6("lines", 6'h01, {4'h0, sclIn, sdaIn});
    tally_and_finish;
  end
endmodule
